//--- hdl/pke_pkg.sv
package pke_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [11:0] IDX_CONTROL = 12'hb00;
    localparam logic [11:0] IDX_STATUS = 12'hb02;
    localparam logic [11:0] IDX_MASK = 12'hb04;
    localparam logic [11:0] IDX_EXP = 12'hb08;

    localparam int unsigned ADR_W = 16;
    localparam int unsigned REG_W = 16;
    localparam int unsigned EXP_W = 32;

    // engine_status_flags fields
    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_ERR = 1;
    localparam int unsigned ST_OOB = 2;
    localparam int unsigned ST_IRQ = 3;
    localparam int unsigned ST_ERDY = 4;
    localparam logic [15:0] STATUS_RST = 16'h0001;
    // bits that may request an interrupt (the irq mirror itself never does)
    localparam logic [15:0] IRQ_SRC = 16'h0017;

    // engine_control_reg fields
    localparam int unsigned CTL_GO = 0;
    localparam int unsigned CTL_IE = 1;
    localparam int unsigned CTL_SRST = 2;
    localparam int unsigned CTL_ECC = 3;
    localparam logic [15:0] CONTROL_RST = 16'h0000;

    // interrupt_mask_reg shares the status layout
    localparam logic [15:0] MASK_IMPL = 16'h001f;
    localparam logic [15:0] MASK_RST = 16'h0000;

    // clear-all boot routine
    localparam int unsigned CLR_AW = 8;
    localparam logic [7:0] CLR_LAST = 8'hff;
    localparam logic [7:0] CLR_ADDR_RST = 8'h00;

    typedef enum logic [2:0] {
        PKE_BOOT_IDLE = 3'b001,
        PKE_BOOT_CLEAR = 3'b010,
        PKE_BOOT_FINISH = 3'b100
    } pke_boot_type;

endpackage : pke_pkg

//--- hdl/pke_boot_clear.sv
`timescale 1ns/1ps
module pke_boot_clear (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic clr_we_o,
    output logic [pke_pkg::CLR_AW-1:0] clr_addr_o,
    output logic finish_o
);

    pke_pkg::pke_boot_type state_q;
    pke_pkg::pke_boot_type state_d;
    logic [pke_pkg::CLR_AW-1:0] addr_q;
    logic [pke_pkg::CLR_AW-1:0] addr_d;

    ////////////////////////////////////////////////////////////////////////////////
    // the engine leaves reset already sweeping its rams, so nothing is needed to launch boot
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        case (state_q)
            pke_pkg::PKE_BOOT_IDLE: begin
                addr_d = pke_pkg::CLR_ADDR_RST;
            end
            pke_pkg::PKE_BOOT_CLEAR: begin
                addr_d = addr_q + 1'b1;
                if (addr_q == pke_pkg::CLR_LAST) begin
                    state_d = pke_pkg::PKE_BOOT_FINISH;
                end
            end
            pke_pkg::PKE_BOOT_FINISH: begin
                state_d = pke_pkg::PKE_BOOT_IDLE;
            end
            default: begin
                state_d = pke_pkg::PKE_BOOT_IDLE;
            end
        endcase
        if (start_i) begin
            state_d = pke_pkg::PKE_BOOT_CLEAR;
            addr_d = pke_pkg::CLR_ADDR_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= pke_pkg::PKE_BOOT_CLEAR;
            addr_q <= pke_pkg::CLR_ADDR_RST;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
        end
    end

    assign busy_o = (state_q != pke_pkg::PKE_BOOT_IDLE);
    assign clr_we_o = (state_q == pke_pkg::PKE_BOOT_CLEAR);
    assign clr_addr_o = addr_q;
    assign finish_o = (state_q == pke_pkg::PKE_BOOT_FINISH);

endmodule : pke_boot_clear

//--- hdl/pke_status_irq.sv
`timescale 1ns/1ps
// Function
// - any host write to the status register clears it, data ignored
// - after run starts, first jump to location 0 sets done, then interrupt
// - done flag set whenever the engine branches to location 0
// - reset leaves status at only the done flag set
// - boot runs clear-all over the rams; engine busy until done reported
// - exponent ready flag set when engine can take the next exponent word
// - writing the exponent register clears exponent ready and its interrupt
// - interrupt drop after an exponent write lags one cycle, in the same edge as the status clear
// - status irq bit mirrors interrupt condition even with enable clear
// - access to an unknown or reserved address sets out-of-bounds flag
// - any other engine error sets the general error flag
// - interrupt output held low while interrupt enable is zero
// - any set unmasked status flag drives the interrupt while enable is one
// - a status bit whose mask bit is one never raises the interrupt
module pke_status_irq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pke_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic jump_zero_i,
    input wire logic engine_error_i,
    input wire logic exp_take_i,
    output logic [pke_pkg::EXP_W-1:0] exp_word_o,
    output logic exp_valid_o,
    output logic run_o,
    output logic ecc_mode_o,
    output logic busy_o,
    output logic clr_we_o,
    output logic [pke_pkg::CLR_AW-1:0] clr_addr_o,
    output logic irq_o
);

    function automatic logic pke_hit(input logic [pke_pkg::ADR_W-1:0] adr, input logic [11:0] idx);
        pke_hit = (adr[pke_pkg::ADR_W-1:2] == {2'b00, idx});
    endfunction : pke_hit

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic req;
    logic wr;
    logic hit_ctl;
    logic hit_st;
    logic hit_mk;
    logic hit_ex;
    logic unmapped;
    logic soft_rst;
    logic hit_any;
    logic rd_req;
    logic ex_wr;

    // accesses act at the edge that raises ack, so each is seen exactly once
    assign req = cyc_i & stb_i & ~ack_q;
    assign wr = req & we_i;
    assign rd_req = req & ~we_i;
    assign hit_ctl = pke_hit(adr_i, pke_pkg::IDX_CONTROL);
    assign hit_st = pke_hit(adr_i, pke_pkg::IDX_STATUS);
    assign hit_mk = pke_hit(adr_i, pke_pkg::IDX_MASK);
    assign hit_ex = pke_hit(adr_i, pke_pkg::IDX_EXP);
    assign hit_any = hit_ctl | hit_st | hit_mk | hit_ex;
    assign unmapped = req & ~hit_any;
    assign ex_wr = wr & hit_ex;
    // soft reset acts on the write itself, in the same edge that raises ack
    assign soft_rst = wr & hit_ctl & sel_i[0] & dat_i[pke_pkg::CTL_SRST];

    ////////////////////////////////////////////////////////////////////////////////
    // clear-all boot

    logic boot_busy;
    logic boot_finish;

    pke_boot_clear u_boot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(soft_rst),
        .busy_o(boot_busy),
        .clr_we_o(clr_we_o),
        .clr_addr_o(clr_addr_o),
        .finish_o(boot_finish)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // control and mask

    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic [15:0] mask_q;
    logic [15:0] mask_d;
    logic go_start;

    always_comb begin
        ctl_d = ctl_q;
        mask_d = mask_q;
        if (wr & hit_ctl) begin
            if (sel_i[0]) begin
                ctl_d[pke_pkg::CTL_IE] = dat_i[pke_pkg::CTL_IE];
                ctl_d[pke_pkg::CTL_ECC] = dat_i[pke_pkg::CTL_ECC];
                // a run cannot start over a ram sweep still in progress
                ctl_d[pke_pkg::CTL_GO] = dat_i[pke_pkg::CTL_GO] & ~boot_busy;
            end
        end
        // the engine halts at the jump to location 0
        if (jump_zero_i) begin
            ctl_d[pke_pkg::CTL_GO] = 1'b0;
        end
        if (wr & hit_mk) begin
            if (sel_i[0]) begin
                mask_d[7:0] = dat_i[7:0] & pke_pkg::MASK_IMPL[7:0];
            end
            if (sel_i[1]) begin
                mask_d[15:8] = dat_i[15:8] & pke_pkg::MASK_IMPL[15:8];
            end
        end
        if (soft_rst) begin
            ctl_d = pke_pkg::CONTROL_RST;
            mask_d = pke_pkg::MASK_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= pke_pkg::CONTROL_RST;
            mask_q <= pke_pkg::MASK_RST;
        end else begin
            ctl_q <= ctl_d;
            mask_q <= mask_d;
        end
    end

    assign go_start = ctl_d[pke_pkg::CTL_GO] & ~ctl_q[pke_pkg::CTL_GO];

    ////////////////////////////////////////////////////////////////////////////////
    // exponent staging word

    logic [pke_pkg::EXP_W-1:0] exp_q;
    logic [pke_pkg::EXP_W-1:0] exp_d;
    logic exp_valid_q;
    logic exp_valid_d;
    logic erdy_set;
    logic [3:0] lane_we;
    logic [pke_pkg::EXP_W-1:0] lane_word;

    // each byte lane has its own strobe so a partial write leaves the other lanes staged
    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign lane_we[g] = ex_wr & sel_i[g];
        assign lane_word[g*8 +: 8] = lane_we[g] ? dat_i[g*8 +: 8] : exp_q[g*8 +: 8];
    end

    // staged word plus the engine's working word form the double buffer
    always_comb begin
        exp_d = exp_q;
        exp_valid_d = exp_valid_q;
        if (exp_take_i) begin
            exp_valid_d = 1'b0;
        end
        if (ex_wr) begin
            exp_d = lane_word;
            exp_valid_d = 1'b1;
        end
        if (soft_rst) begin
            exp_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exp_q <= '0;
            exp_valid_q <= 1'b0;
        end else begin
            exp_q <= exp_d;
            exp_valid_q <= exp_valid_d;
        end
    end

    // ready when the engine drains the staged word, or a run starts with none staged
    // a write in the drain cycle stages a fresh word, so ready stays clear then
    assign erdy_set = (exp_take_i & exp_valid_q & ~ex_wr) | (go_start & ~exp_valid_q);

    ////////////////////////////////////////////////////////////////////////////////
    // status flags and interrupt

    logic [15:0] status_q;
    logic [15:0] status_d;
    logic irq_q;
    logic irq_d;
    logic pending;
    logic done_set;

    assign done_set = jump_zero_i | boot_finish;

    always_comb begin
        status_d = status_q;
        if (wr & hit_st) begin
            status_d = '0;
        end
        if (ex_wr) begin
            status_d[pke_pkg::ST_ERDY] = 1'b0;
        end
        // new events win over a status write clear in the same cycle, an exponent write wins over a drain, soft reset wins over all; flags are otherwise held
        if (done_set) begin
            status_d[pke_pkg::ST_DONE] = 1'b1;
        end
        if (engine_error_i) begin
            status_d[pke_pkg::ST_ERR] = 1'b1;
        end
        if (unmapped) begin
            status_d[pke_pkg::ST_OOB] = 1'b1;
        end
        if (erdy_set) begin
            status_d[pke_pkg::ST_ERDY] = 1'b1;
        end
        if (soft_rst) begin
            status_d = pke_pkg::STATUS_RST;
        end
        // reserved bits never hold a one
        status_d = status_d & pke_pkg::IRQ_SRC;
        pending = |(status_d & pke_pkg::IRQ_SRC & ~mask_d);
        status_d[pke_pkg::ST_IRQ] = pending;
        irq_d = pending & ctl_d[pke_pkg::CTL_IE];
    end

    // one register stage on irq gives the short lag after an exponent write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= pke_pkg::STATUS_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus answer

    logic [31:0] rd_word;

    // reads of unmapped indices return zero; the out-of-bounds flag tells software why
    always_comb begin
        rd_word = '0;
        case (1'b1)
            hit_ctl: begin
                rd_word[15:0] = ctl_q;
            end
            hit_st: begin
                rd_word[15:0] = status_q;
            end
            hit_mk: begin
                rd_word[15:0] = mask_q;
            end
            hit_ex: begin
                rd_word = exp_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // read data is registered with ack so it stands in the one cycle the master samples it
    always_comb begin
        ack_d = req;
        dat_d = dat_q;
        if (rd_req) begin
            dat_d = rd_word;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign irq_o = irq_q;
    assign run_o = ctl_q[pke_pkg::CTL_GO];
    assign ecc_mode_o = ctl_q[pke_pkg::CTL_ECC];
    assign busy_o = boot_busy;
    assign exp_word_o = exp_q;
    assign exp_valid_o = exp_valid_q;

endmodule : pke_status_irq

//--- tb/pke_status_irq_props.sv
`timescale 1ns/1ps
module pke_status_irq_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic jump_zero_i,
    input wire logic engine_error_i,
    input wire logic exp_take_i,
    input wire logic [31:0] exp_word_o,
    input wire logic exp_valid_o,
    input wire logic run_o,
    input wire logic busy_o,
    input wire logic clr_we_o,
    input wire logic [7:0] clr_addr_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [13:0] idx = adr_i[15:2];
    // no event may race the clear, or the flag rightly survives it
    wire quiet = !jump_zero_i && !engine_error_i && !exp_take_i && !busy_o;
    ////////////////////////////////////////
    sequence taken_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence st_wr_s;
        taken_s ##0 (we_i && idx == {2'b00, pke_pkg::IDX_STATUS});
    endsequence
    sequence exp_wr_s;
        taken_s ##0 (we_i && idx == {2'b00, pke_pkg::IDX_EXP});
    endsequence
    ////////////////////////////////////////
    ack_answer_a: assert property (taken_s |=> ack_o)
        else $error("request not answered");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    status_clear_a: assert property (st_wr_s ##0 quiet |=> !irq_o)
        else $error("status write left irq set");
    boot_start_a: assert property ($fell(rst_i) |-> busy_o && clr_we_o && clr_addr_o == 8'h00)
        else $error("boot sweep not started");
    // a soft reset write may restart the sweep from zero at any step
    sweep_step_a: assert property (clr_we_o && clr_addr_o != 8'hff && !(cyc_i && stb_i && we_i && !ack_o) |=>
        clr_we_o && clr_addr_o == $past(clr_addr_o) + 8'h01)
        else $error("sweep address skipped");
    sweep_end_a: assert property (clr_we_o && clr_addr_o == 8'hff |=> busy_o && !clr_we_o ##1 !busy_o)
        else $error("sweep end wrong");
    exp_load_a: assert property (exp_wr_s ##0 sel_i == 4'hf |=> exp_valid_o && exp_word_o == $past(dat_i))
        else $error("exponent word not staged");
    go_stop_a: assert property (jump_zero_i && !(cyc_i && stb_i) |=> !run_o)
        else $error("run kept after jump");
    irq_cause_a: assert property ($rose(irq_o) |->
        $past(jump_zero_i || engine_error_i || exp_take_i || busy_o || (cyc_i && stb_i)))
        else $error("irq without cause");
endmodule : pke_status_irq_props
bind pke_status_irq pke_status_irq_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .ack_o, .jump_zero_i, .engine_error_i, .exp_take_i, .exp_word_o, .exp_valid_o, .run_o,
    .busy_o, .clr_we_o, .clr_addr_o, .irq_o);

//--- tb/pke_host_model.sv
`timescale 1ns/1ps
module pke_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [15:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 16'h0000;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // call right after a rising edge; waits with no cycle limit
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released lines must not look like a held request
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask : wb
endmodule : pke_host_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] A_CTL = {2'b00, pke_pkg::IDX_CONTROL, 2'b00};
    localparam logic [15:0] A_ST = {2'b00, pke_pkg::IDX_STATUS, 2'b00};
    localparam logic [15:0] A_MSK = {2'b00, pke_pkg::IDX_MASK, 2'b00};
    localparam logic [15:0] A_EXP = {2'b00, pke_pkg::IDX_EXP, 2'b00};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i, stb_i, we_i, ack_o, exp_valid_o, run_o, ecc_mode_o, busy_o, clr_we_o, irq_o;
    logic [15:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, exp_word_o;
    logic [7:0] clr_addr_o;
    logic [2:0] ev = 3'b000;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    pke_status_irq i_pke_status_irq (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .jump_zero_i(ev[0]), .engine_error_i(ev[1]), .exp_take_i(ev[2]), .exp_word_o,
        .exp_valid_o, .run_o, .ecc_mode_o, .busy_o, .clr_we_o, .clr_addr_o, .irq_o);
    pke_host_model host (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
        .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string m);
        checks++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    task automatic rd(input logic [15:0] a, input logic [31:0] want, input string m);
        logic [31:0] q;
        host.wb(1'b0, a, 32'h0, q);
        check(q, want, m);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.wb(1'b1, a, d, q);
    endtask : wr
    // one-cycle engine event; flags are settled when this returns
    task automatic fire(input int b);
        ev[b] <= 1'b1;
        @(posedge clk_i);
        ev <= 3'b000;
        @(posedge clk_i);
    endtask : fire
    task automatic close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////
    task automatic t_boot();
        int n;
        n = 0;
        @(posedge clk_i);
        while (busy_o === 1'b1 && n < 400) begin
            n++;
            @(posedge clk_i);
        end
        check(32'(n), 32'd257, "boot length");
        // done from reset shows in the unmasked irq mirror one edge later
        rd(A_ST, 32'h0009, "status reset");
        rd(A_MSK, 32'h0, "mask reset");
        rd(A_CTL, 32'h0, "control reset");
    endtask : t_boot
    task automatic t_flags();
        wr(A_ST, 32'h0);
        rd(A_ST, 32'h0, "status not cleared");
        fire(1);
        rd(A_ST, 32'h000a, "error flag");
        check({31'h0, irq_o}, 32'h0, "irq while disabled");
        wr(16'h2ff0, 32'h0);
        rd(A_ST, 32'h000e, "oob flag");
        wr(A_ST, 32'h0);
        fire(0);
        rd(A_ST, 32'h0009, "done flag");
    endtask : t_flags
    task automatic t_irq();
        wr(A_CTL, 32'h2);
        check({31'h0, irq_o}, 32'h1, "irq not raised");
        wr(A_MSK, 32'h0001);
        check({31'h0, irq_o}, 32'h0, "masked irq");
        rd(A_ST, 32'h0001, "mirror masked");
        wr(A_MSK, 32'h0);
        wr(A_ST, 32'h0);
        check({31'h0, irq_o}, 32'h0, "irq after clear");
    endtask : t_irq
    task automatic t_exp();
        wr(A_CTL, 32'hb);
        check({31'h0, run_o}, 32'h1, "run");
        check({31'h0, ecc_mode_o}, 32'h1, "ecc mode");
        rd(A_ST, 32'h0018, "exp ready");
        wr(A_EXP, 32'h89abcdef);
        check({31'h0, irq_o}, 32'h0, "irq after exp write");
        check(exp_word_o, 32'h89abcdef, "exp word");
        rd(A_ST, 32'h0, "exp ready kept");
        fire(2);
        rd(A_ST, 32'h0018, "exp ready again");
        wr(A_MSK, 32'h0010);
        check({31'h0, irq_o}, 32'h0, "exp ready masked");
        fire(0);
        check({31'h0, run_o}, 32'h0, "run after jump");
        check({31'h0, irq_o}, 32'h1, "irq on done");
        rd(A_ST, 32'h0019, "done and ready");
        wr(A_CTL, 32'h4);
        check({31'h0, busy_o}, 32'h1, "soft reset sweep");
        check({31'h0, irq_o}, 32'h0, "soft reset irq");
    endtask : t_exp
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_flags();
        t_irq();
        t_exp();
        close_out();
    end
endmodule : tb_top
